// ===== pkg/buck_cfg_pkg.sv
// constants, register map and field layout of the two-channel buck configuration slice
// assumes a 32-bit APB slave in front; the registers hold 8 bits in the low byte lane
// Overview of operation
// - current limit code bits 5:3 decode 1.5-3.0 A
// - limit change applies while channel stays running
// - ramp code bits 2:0, codes 2-7 valid
// - control bit 3 forces fixed switching mode
// - control bit 2 connects discharge when off
// - control bit 1 gates enable with pin
// - control bit 0 turns channel on or off
// - voltage codes 0x14-0x17 give 10 mV steps
// - voltage codes 0x18-0x9d give 5 mV steps
// - voltage codes 0x9e-0xff give 20 mV steps
package buck_cfg_pkg;
    // bus and storage widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W = 8;
    localparam int unsigned MA_W = 12;
    localparam int unsigned UV_W = 14;
    localparam int unsigned MV_W = 12;
    localparam int unsigned SYNC_STAGES = 3;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CH0_LIMIT_SLEW = 10'h003;
    localparam logic [9:0] IDX_CH1_CONTROL = 10'h004;
    localparam logic [9:0] IDX_CH1_LIMIT_SLEW = 10'h005;
    localparam logic [9:0] IDX_CH0_VOLTAGE = 10'h006;
    localparam logic [9:0] IDX_CH1_VOLTAGE = 10'h007;
    // field positions
    localparam int unsigned LIMIT_LSB = 3;
    localparam int unsigned RAMP_LSB = 0;
    localparam int unsigned FORCE_BIT = 3;
    localparam int unsigned DISCH_BIT = 2;
    localparam int unsigned PIN_GATE_BIT = 1;
    localparam int unsigned TURN_ON_BIT = 0;
    // reset values
    localparam logic [7:0] RST_LIMIT_SLEW = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h04;
    localparam logic [7:0] RST_VOLTAGE = 8'h14;
    // current limit: 1500 mA plus 500 mA per code up to code 3
    localparam logic [11:0] LIMIT_BASE_MA = 12'h5dc;
    localparam logic [11:0] LIMIT_STEP_MA = 12'h1f4;
    localparam logic [2:0] LIMIT_MAX_CODE = 3'h3;
    // ramp rates in uV/us for codes 2..7
    localparam logic [13:0] RAMP_C2_UV = 14'h2710;
    localparam logic [13:0] RAMP_C3_UV = 14'h1d4c;
    localparam logic [13:0] RAMP_C4_UV = 14'h0ed8;
    localparam logic [13:0] RAMP_C5_UV = 14'h076c;
    localparam logic [13:0] RAMP_C6_UV = 14'h03ac;
    localparam logic [13:0] RAMP_C7_UV = 14'h01d6;
    // voltage segments: first code, base mV, step mV
    localparam logic [7:0] V_LO_FIRST = 8'h14;
    localparam logic [7:0] V_MID_FIRST = 8'h18;
    localparam logic [7:0] V_HI_FIRST = 8'h9e;
    localparam logic [11:0] V_LO_BASE_MV = 12'h2bc;
    localparam logic [11:0] V_MID_BASE_MV = 12'h2df;
    localparam logic [11:0] V_HI_BASE_MV = 12'h58c;
    localparam logic [11:0] V_LO_STEP_MV = 12'h00a;
    localparam logic [11:0] V_MID_STEP_MV = 12'h005;
    localparam logic [11:0] V_HI_STEP_MV = 12'h014;
endpackage

// ===== pkg/chan_decode_if.sv
// bundle between the register file and one channel's field decoder
// assumes both ends share the core clock
`timescale 1ns/1ps
interface chan_decode_if;
    import buck_cfg_pkg::*;
    logic [2:0] limit_code; // raw current limit field
    logic [2:0] ramp_code; // raw ramp field
    logic [7:0] voltage_code; // raw voltage code
    logic [MA_W-1:0] current_limit_ma; // decoded limit
    logic limit_valid; // limit code is a defined one
    logic [UV_W-1:0] ramp_uv_per_us; // decoded ramp rate
    logic ramp_valid; // ramp code is a defined one
    logic [MV_W-1:0] voltage_mv; // decoded target voltage
    logic voltage_valid; // voltage code is a defined one
    modport regs (output limit_code, ramp_code, voltage_code,
        input current_limit_ma, limit_valid, ramp_uv_per_us, ramp_valid,
        voltage_mv, voltage_valid);
    modport decoder (input limit_code, ramp_code, voltage_code,
        output current_limit_ma, limit_valid, ramp_uv_per_us, ramp_valid,
        voltage_mv, voltage_valid);
endinterface // chan_decode_if

// ===== rtl/buck_chan_decode.sv
// field decoder for one buck channel, outputs registered one cycle after the codes
// assumes codes come from registers on the same clock
`timescale 1ns/1ps
module buck_chan_decode
    import buck_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    chan_decode_if.decoder dec
);
    logic [MA_W-1:0] next_ma; // combinational limit
    logic [UV_W-1:0] next_uv; // combinational ramp
    logic [MV_W-1:0] next_mv; // combinational voltage
    logic next_lv, next_rv, next_vv; // validity flags

    // decode all three fields; codes are live, so a change applies without any
    // enable handshake and a running channel simply sees the new value
    always_comb begin
        next_lv = (dec.limit_code <= LIMIT_MAX_CODE);
        next_ma = next_lv ? MA_W'(LIMIT_BASE_MA + MA_W'(LIMIT_STEP_MA * MA_W'(dec.limit_code)))
                          : '0;
        next_rv = 1'b1;
        case (dec.ramp_code)
            3'h2: next_uv = RAMP_C2_UV;
            3'h3: next_uv = RAMP_C3_UV;
            3'h4: next_uv = RAMP_C4_UV;
            3'h5: next_uv = RAMP_C5_UV;
            3'h6: next_uv = RAMP_C6_UV;
            3'h7: next_uv = RAMP_C7_UV;
            default: begin
                next_uv = '0; // reserved codes give no ramp
                next_rv = 1'b0;
            end
        endcase
        next_vv = 1'b1;
        if (dec.voltage_code >= V_HI_FIRST) begin
            next_mv = MV_W'(V_HI_BASE_MV
                + MV_W'(V_HI_STEP_MV * MV_W'(dec.voltage_code - V_HI_FIRST)));
        end else if (dec.voltage_code >= V_MID_FIRST) begin
            next_mv = MV_W'(V_MID_BASE_MV
                + MV_W'(V_MID_STEP_MV * MV_W'(dec.voltage_code - V_MID_FIRST)));
        end else if (dec.voltage_code >= V_LO_FIRST) begin
            next_mv = MV_W'(V_LO_BASE_MV
                + MV_W'(V_LO_STEP_MV * MV_W'(dec.voltage_code - V_LO_FIRST)));
        end else begin
            next_mv = '0; // reserved low codes: no defined output
            next_vv = 1'b0;
        end
    end

    // output flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec.current_limit_ma <= '0;
            dec.limit_valid <= 1'b0;
            dec.ramp_uv_per_us <= '0;
            dec.ramp_valid <= 1'b0;
            dec.voltage_mv <= '0;
            dec.voltage_valid <= 1'b0;
        end else begin
            dec.current_limit_ma <= next_ma;
            dec.limit_valid <= next_lv;
            dec.ramp_uv_per_us <= next_uv;
            dec.ramp_valid <= next_rv;
            dec.voltage_mv <= next_mv;
            dec.voltage_valid <= next_vv;
        end
    end

    property p_limit_decode;
        @(posedge clk) disable iff (!rst_n)
        (dec.limit_code == 3'h2) |=> (dec.current_limit_ma == 12'h9c4) && dec.limit_valid;
    endproperty
    a_limit_decode: assert property (p_limit_decode)
        else $error("limit code 2 not decoded to 2500 mA");

    property p_ramp_reserved;
        @(posedge clk) disable iff (!rst_n)
        (dec.ramp_code < 3'h2) |=> !dec.ramp_valid ##0 (dec.ramp_uv_per_us == '0);
    endproperty
    a_ramp_reserved: assert property (p_ramp_reserved)
        else $error("reserved ramp code flagged valid");

    property p_volt_low;
        @(posedge clk) disable iff (!rst_n)
        (dec.voltage_code == 8'h17) |=> (dec.voltage_mv == 12'h2da) && dec.voltage_valid;
    endproperty
    a_volt_low: assert property (p_volt_low)
        else $error("code 0x17 not 730 mV");

    property p_volt_mid;
        @(posedge clk) disable iff (!rst_n)
        (dec.voltage_code == 8'h9d) |=> (dec.voltage_mv == 12'h578);
    endproperty
    a_volt_mid: assert property (p_volt_mid)
        else $error("code 0x9d not 1400 mV");

    property p_volt_high;
        @(posedge clk) disable iff (!rst_n)
        (dec.voltage_code == 8'hff) |=> (dec.voltage_mv == 12'hd20);
    endproperty
    a_volt_high: assert property (p_volt_high)
        else $error("code 0xff not 3360 mV");
endmodule // buck_chan_decode

// ===== rtl/buck_regulator_config_regs.sv
// register bank for the two buck channels behind an APB slave, plus the
// second channel's enable, mode and discharge control
// assumes an APB master on CORE_CLK (40 MHz) and an asynchronous EN_PIN
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module buck_regulator_config_regs
    import buck_cfg_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EN_PIN,
    output logic [MA_W-1:0] CH0_CURRENT_LIMIT_MA,
    output logic CH0_LIMIT_VALID,
    output logic [UV_W-1:0] CH0_RAMP_UV_PER_US,
    output logic CH0_RAMP_VALID,
    output logic [MV_W-1:0] CH0_VOLTAGE_MV,
    output logic CH0_VOLTAGE_VALID,
    output logic [MA_W-1:0] CH1_CURRENT_LIMIT_MA,
    output logic CH1_LIMIT_VALID,
    output logic [UV_W-1:0] CH1_RAMP_UV_PER_US,
    output logic CH1_RAMP_VALID,
    output logic [MV_W-1:0] CH1_VOLTAGE_MV,
    output logic CH1_VOLTAGE_VALID,
    output logic CH1_FORCE_FIXED_SWITCHING,
    output logic CH1_PULSE_FREQUENCY_OPERATION,
    output logic CH1_DISCHARGE_CONNECT,
    output logic CH1_RUN
);
    // reset synchroniser
    logic rst_meta; // first stage, read only by rst_n
    logic rst_n; // released copy used everywhere

    // pin synchroniser
    logic en_meta; // first stage, read only by en_s2
    logic en_s2; // second stage
    logic en_s3; // third stage
    logic en_level; // filtered pin level

    // storage; all eight bits kept so reserved bits read back as written
    logic [7:0] ch0_limit_slew; // channel 0 limit and ramp
    logic [7:0] ch1_control; // channel 1 control byte
    logic [7:0] ch1_limit_slew; // channel 1 limit and ramp
    logic [7:0] ch0_voltage_code; // channel 0 voltage code
    logic [7:0] ch1_voltage_code; // channel 1 voltage code

    // bus decode
    logic setup_phase; // first cycle of a transfer
    logic access_phase; // completing cycle
    logic addr_hit; // address names a register
    logic [7:0] read_mux; // byte selected by address
    logic wr_byte; // write that lands this cycle

    // channel 1 control fields
    logic ch1_force_fixed_switching;
    logic ch1_discharge_on_off;
    logic ch1_pin_gated_enable;
    logic ch1_turn_on;
    logic next_run; // channel 1 run request

    chan_decode_if dec0 ();
    chan_decode_if dec1 ();

    // release reset through two flops; assertion is immediate
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // three-flop pin sampling; a change only counts when stages two and three agree
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            en_meta <= 1'b0;
            en_s2 <= 1'b0;
            en_s3 <= 1'b0;
            en_level <= 1'b0;
        end else begin
            en_meta <= EN_PIN;
            en_s2 <= en_meta;
            en_s3 <= en_s2;
            if (en_s2 == en_s3) begin
                en_level <= en_s3; // stable for two samples
            end
        end
    end

    // apb phase and address decode; unaligned or upper addresses miss
    assign setup_phase = PSEL && !PENABLE;
    assign access_phase = PSEL && PENABLE;
    always_comb begin
        addr_hit = (PADDR[1:0] == 2'h0);
        case (PADDR[ADDR_W-1:2])
            IDX_CH0_LIMIT_SLEW: read_mux = ch0_limit_slew;
            IDX_CH1_CONTROL: read_mux = ch1_control;
            IDX_CH1_LIMIT_SLEW: read_mux = ch1_limit_slew;
            IDX_CH0_VOLTAGE: read_mux = ch0_voltage_code;
            IDX_CH1_VOLTAGE: read_mux = ch1_voltage_code;
            default: begin
                read_mux = 8'h00; // unmapped reads return zero
                addr_hit = 1'b0;
            end
        endcase
    end

    // zero wait state: the read byte is captured in setup, so access always completes
    assign PREADY = 1'b1;
    assign PSLVERR = access_phase && !addr_hit;
    // only lane 0 carries data; a write without strobe 0 changes nothing
    assign wr_byte = access_phase && PWRITE && addr_hit && PSTRB[0];

    // read data flop, loaded in the setup cycle and held through the access
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= '0;
        end else if (setup_phase && !PWRITE) begin
            PRDATA <= {24'h000000, read_mux};
        end
    end

    // channel 0 limit and ramp; may change at any moment
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ch0_limit_slew <= RST_LIMIT_SLEW;
        end else if (wr_byte && PADDR[ADDR_W-1:2] == IDX_CH0_LIMIT_SLEW) begin
            ch0_limit_slew <= PWDATA[7:0];
        end
    end

    // channel 1 control byte; discharge bit comes out of reset set
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ch1_control <= RST_CONTROL;
        end else if (wr_byte && PADDR[ADDR_W-1:2] == IDX_CH1_CONTROL) begin
            ch1_control <= PWDATA[7:0];
        end
    end

    // channel 1 limit and ramp
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ch1_limit_slew <= RST_LIMIT_SLEW;
        end else if (wr_byte && PADDR[ADDR_W-1:2] == IDX_CH1_LIMIT_SLEW) begin
            ch1_limit_slew <= PWDATA[7:0];
        end
    end

    // voltage codes; reserved low codes are stored too, the decoder flags them
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ch0_voltage_code <= RST_VOLTAGE;
            ch1_voltage_code <= RST_VOLTAGE;
        end else if (wr_byte) begin
            if (PADDR[ADDR_W-1:2] == IDX_CH0_VOLTAGE) begin
                ch0_voltage_code <= PWDATA[7:0];
            end
            if (PADDR[ADDR_W-1:2] == IDX_CH1_VOLTAGE) begin
                ch1_voltage_code <= PWDATA[7:0];
            end
        end
    end

    // field split of the control byte
    assign ch1_force_fixed_switching = ch1_control[FORCE_BIT];
    assign ch1_discharge_on_off = ch1_control[DISCH_BIT];
    assign ch1_pin_gated_enable = ch1_control[PIN_GATE_BIT];
    assign ch1_turn_on = ch1_control[TURN_ON_BIT];

    // mode outputs come straight from the register bit
    assign CH1_FORCE_FIXED_SWITCHING = ch1_force_fixed_switching;
    assign CH1_PULSE_FREQUENCY_OPERATION = !ch1_force_fixed_switching;

    // enable source: bit alone, or bit together with the pin
    assign next_run = ch1_turn_on && (!ch1_pin_gated_enable || en_level);

    // run and discharge flops; discharge only while the channel is off, so the
    // resistor never fights a running output
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CH1_RUN <= 1'b0;
            CH1_DISCHARGE_CONNECT <= 1'b0;
        end else begin
            CH1_RUN <= next_run;
            CH1_DISCHARGE_CONNECT <= ch1_discharge_on_off && !next_run;
        end
    end

    // feed codes to the two decoders
    assign dec0.limit_code = ch0_limit_slew[LIMIT_LSB +: 3];
    assign dec0.ramp_code = ch0_limit_slew[RAMP_LSB +: 3];
    assign dec0.voltage_code = ch0_voltage_code;
    assign dec1.limit_code = ch1_limit_slew[LIMIT_LSB +: 3];
    assign dec1.ramp_code = ch1_limit_slew[RAMP_LSB +: 3];
    assign dec1.voltage_code = ch1_voltage_code;

    buck_chan_decode u_dec0 (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .dec(dec0)
    );

    buck_chan_decode u_dec1 (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .dec(dec1)
    );

    // decoded values to the regulator control logic
    assign CH0_CURRENT_LIMIT_MA = dec0.current_limit_ma;
    assign CH0_LIMIT_VALID = dec0.limit_valid;
    assign CH0_RAMP_UV_PER_US = dec0.ramp_uv_per_us;
    assign CH0_RAMP_VALID = dec0.ramp_valid;
    assign CH0_VOLTAGE_MV = dec0.voltage_mv;
    assign CH0_VOLTAGE_VALID = dec0.voltage_valid;
    assign CH1_CURRENT_LIMIT_MA = dec1.current_limit_ma;
    assign CH1_LIMIT_VALID = dec1.limit_valid;
    assign CH1_RAMP_UV_PER_US = dec1.ramp_uv_per_us;
    assign CH1_RAMP_VALID = dec1.ramp_valid;
    assign CH1_VOLTAGE_MV = dec1.voltage_mv;
    assign CH1_VOLTAGE_VALID = dec1.voltage_valid;

    // a completed write followed at once by a read of the same word
    sequence s_write_done;
        wr_byte;
    endsequence
    sequence s_read_setup;
        setup_phase && !PWRITE && addr_hit && PADDR == $past(PADDR);
    endsequence

    property p_readback;
        @(posedge CORE_CLK) disable iff (!rst_n)
        s_write_done ##1 s_read_setup |=> PRDATA == {24'h000000, $past(PWDATA[7:0], 2)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("register did not read back written byte");

    property p_limit_live;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (wr_byte && PADDR[ADDR_W-1:2] == IDX_CH1_LIMIT_SLEW && CH1_RUN
            && PWDATA[5:3] == 3'h3 && ch1_turn_on && !ch1_pin_gated_enable)
        |-> ##2 (CH1_CURRENT_LIMIT_MA == 12'hbb8) && CH1_RUN;
    endproperty
    a_limit_live: assert property (p_limit_live)
        else $error("limit change not applied while running");

    property p_force_mode;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (wr_byte && PADDR[ADDR_W-1:2] == IDX_CH1_CONTROL)
        |=> (CH1_FORCE_FIXED_SWITCHING == $past(PWDATA[3]))
            && (CH1_PULSE_FREQUENCY_OPERATION != CH1_FORCE_FIXED_SWITCHING);
    endproperty
    a_force_mode: assert property (p_force_mode)
        else $error("mode bit not reflected");

    property p_discharge;
        @(posedge CORE_CLK) disable iff (!rst_n)
        $past(rst_n) |-> CH1_DISCHARGE_CONNECT == ($past(ch1_discharge_on_off) && !CH1_RUN);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge not tied to off state");

    property p_pin_gate;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (ch1_turn_on && ch1_pin_gated_enable && !en_level) |=> !CH1_RUN;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("channel runs with pin low under pin gating");

    property p_turn_on;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (ch1_turn_on && !ch1_pin_gated_enable) [*2] |=> CH1_RUN;
    endproperty
    a_turn_on: assert property (p_turn_on)
        else $error("channel not running with enable bit set");

    property p_turn_off;
        @(posedge CORE_CLK) disable iff (!rst_n)
        !ch1_turn_on |=> !CH1_RUN;
    endproperty
    a_turn_off: assert property (p_turn_off)
        else $error("channel running with enable bit clear");
endmodule // buck_regulator_config_regs

// ===== testbench/buck_regulator_config_regs_tb.sv
// self-checking bench for the two-channel buck configuration bank
// assumes a zero-wait apb slave and decoded outputs settled three cycles after a write
`timescale 1ns/1ps
module buck_regulator_config_regs_tb;
    import buck_cfg_pkg::*;
    logic CORE_CLK = 1'b0; // 40 MHz core clock
    logic RESETN = 1'b0; // held low at start
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, EN_PIN = 1'b0; // bus controls and pin
    logic [ADDR_W-1:0] PADDR = '0; // byte address
    logic [DATA_W-1:0] PWDATA = '0; // write data
    logic [3:0] PSTRB = 4'h0; // byte strobes
    logic [DATA_W-1:0] PRDATA; // read data
    logic PREADY, PSLVERR, CH0_LIMIT_VALID, CH0_RAMP_VALID, CH0_VOLTAGE_VALID; // flags
    logic CH1_LIMIT_VALID, CH1_RAMP_VALID, CH1_VOLTAGE_VALID, CH1_RUN; // flags
    logic CH1_FORCE_FIXED_SWITCHING, CH1_PULSE_FREQUENCY_OPERATION, CH1_DISCHARGE_CONNECT;
    logic [MA_W-1:0] CH0_CURRENT_LIMIT_MA, CH1_CURRENT_LIMIT_MA; // decoded limits
    logic [UV_W-1:0] CH0_RAMP_UV_PER_US, CH1_RAMP_UV_PER_US; // decoded ramps
    logic [MV_W-1:0] CH0_VOLTAGE_MV, CH1_VOLTAGE_MV; // decoded voltages
    int err_count = 0; // mismatches
    int num_checks = 0; // comparisons
    int seed = 37; // fixed seed keeps runs repeatable
    int cycles = 0; // watchdog count
    int mdl [3:7]; // expected register contents by index
    logic [31:0] rd; // last read data
    logic rd_err; // last error response
    bit chain = 1'b0; // set when the next setup cycle follows the last access at once
    logic [7:0] vb [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff}; // segment edges

    buck_regulator_config_regs u_dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EN_PIN(EN_PIN),
        .CH0_CURRENT_LIMIT_MA(CH0_CURRENT_LIMIT_MA), .CH0_LIMIT_VALID(CH0_LIMIT_VALID),
        .CH0_RAMP_UV_PER_US(CH0_RAMP_UV_PER_US), .CH0_RAMP_VALID(CH0_RAMP_VALID),
        .CH0_VOLTAGE_MV(CH0_VOLTAGE_MV), .CH0_VOLTAGE_VALID(CH0_VOLTAGE_VALID),
        .CH1_CURRENT_LIMIT_MA(CH1_CURRENT_LIMIT_MA), .CH1_LIMIT_VALID(CH1_LIMIT_VALID),
        .CH1_RAMP_UV_PER_US(CH1_RAMP_UV_PER_US), .CH1_RAMP_VALID(CH1_RAMP_VALID),
        .CH1_VOLTAGE_MV(CH1_VOLTAGE_MV), .CH1_VOLTAGE_VALID(CH1_VOLTAGE_VALID),
        .CH1_FORCE_FIXED_SWITCHING(CH1_FORCE_FIXED_SWITCHING),
        .CH1_PULSE_FREQUENCY_OPERATION(CH1_PULSE_FREQUENCY_OPERATION),
        .CH1_DISCHARGE_CONNECT(CH1_DISCHARGE_CONNECT), .CH1_RUN(CH1_RUN));

    // clock generator
    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    // prints the counts and the verdict, then stops
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the whole run needs far fewer cycles than this
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            close_out();
        end
    end

    // comparison of a value seen on an output port
    task automatic chk_out(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high, only the watchdog
    // ends a wait; with more set the select stays up for an immediate next setup
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
        input logic [3:0] strb, input bit more = 1'b0);
        if (!chain) @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= {24'h0, wd};
        PSTRB <= strb;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        rd_err = PSLVERR;
        chain = more;
        PENABLE <= 1'b0;
        if (!more) PSEL <= 1'b0;
    endtask

    // full write that also updates the model
    task automatic wr(input int idx, input logic [7:0] v, input bit more = 1'b0);
        apb(10'(idx), 1'b1, v, 4'hf, more);
        mdl[idx] = v;
    endtask

    // comparison of register read data against the model
    task automatic chk_reg(input int idx);
        apb(10'(idx), 1'b0, 8'h00, 4'hf);
        chk_out("read data", {24'h0, mdl[idx][7:0]}, rd);
        chk_out("read error", 0, 32'(rd_err));
    endtask

    function automatic int exp_uv(input int c);
        int t [8] = '{0, 0, 10000, 7500, 3800, 1900, 940, 470};
        return t[c];
    endfunction

    function automatic int exp_mv(input int v);
        if (v < 'h14) return 0;
        if (v < 'h18) return 700 + 10 * (v - 'h14);
        if (v < 'h9e) return 735 + 5 * (v - 'h18);
        return 1420 + 20 * (v - 'h9e);
    endfunction

    // legal voltage code only, the low codes are never programmed
    function automatic logic [7:0] rnd_v();
        return 8'(8'h14 + $unsigned($random(seed)) % 236);
    endfunction

    // decoded values of one channel against the model
    task automatic chk_ch(input int ch);
        int ls;
        int v;
        ls = mdl[ch ? 5 : 3];
        v = mdl[ch ? 7 : 6];
        repeat (3) @(posedge CORE_CLK);
        #1;
        chk_out("limit", (ls[5:3] < 4) ? 1500 + 500 * ls[5:3] : 0,
            32'(ch ? CH1_CURRENT_LIMIT_MA : CH0_CURRENT_LIMIT_MA));
        chk_out("limit ok", 32'(ls[5:3] < 4), 32'(ch ? CH1_LIMIT_VALID : CH0_LIMIT_VALID));
        chk_out("ramp", exp_uv(ls[2:0]), 32'(ch ? CH1_RAMP_UV_PER_US : CH0_RAMP_UV_PER_US));
        chk_out("ramp ok", 32'(ls[2:0] > 1), 32'(ch ? CH1_RAMP_VALID : CH0_RAMP_VALID));
        chk_out("volt", exp_mv(v), 32'(ch ? CH1_VOLTAGE_MV : CH0_VOLTAGE_MV));
        chk_out("volt ok", 32'(v > 'h13), 32'(ch ? CH1_VOLTAGE_VALID : CH0_VOLTAGE_VALID));
    endtask

    // control outputs of the second channel; the pin passes a synchroniser first
    task automatic chk_ctl;
        logic [7:0] c;
        logic run;
        c = 8'(mdl[4]);
        run = c[0] & (~c[1] | EN_PIN);
        repeat (8) @(posedge CORE_CLK);
        #1;
        chk_out("force", 32'(c[3]), 32'(CH1_FORCE_FIXED_SWITCHING));
        chk_out("auto mode", 32'(!c[3]), 32'(CH1_PULSE_FREQUENCY_OPERATION));
        chk_out("run", 32'(run), 32'(CH1_RUN));
        chk_out("discharge", 32'(c[2] & ~run), 32'(CH1_DISCHARGE_CONNECT));
    endtask

    // main sequence
    initial begin
        int j; // register picked at random
        repeat (20) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        mdl = '{'h00, 'h04, 'h00, 'h14, 'h14};
        for (int i = 3; i < 8; i++) chk_reg(i);
        chk_ctl();
        $display("reset values done");
        wr(4, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(3, {2'b10, 3'(c), 3'(7 - c)});
            wr(5, {2'b01, 3'(7 - c), 3'(c)});
            chk_ch(0);
            chk_ch(1);
            chk_ctl();
        end
        $display("limit and ramp codes done");
        foreach (vb[i]) begin
            wr(6, vb[i]);
            wr(7, vb[5 - i]);
            chk_ch(0);
            chk_ch(1);
        end
        repeat (20) begin
            wr(6, rnd_v());
            wr(7, rnd_v());
            chk_ch(0);
            chk_ch(1);
        end
        $display("voltage codes done");
        for (int k = 0; k < 32; k++) begin
            @(posedge CORE_CLK);
            EN_PIN <= k[4];
            wr(4, {4'($random(seed)), 4'(k)});
            chk_ctl();
            chk_reg(4);
        end
        $display("control bits done");
        apb(10'h002, 1'b1, 8'haa, 4'hf);
        apb(10'h002, 1'b0, 8'h00, 4'hf);
        chk_out("unmapped data", 0, rd);
        chk_out("unmapped error", 1, 32'(rd_err));
        apb(10'h006, 1'b1, 8'h55, 4'h0);
        chk_reg(6);
        // write then read the same word back to back, no idle cycle between
        repeat (30) begin
            j = 3 + $unsigned($random(seed)) % 5;
            wr(j, rnd_v(), 1'b1);
            chk_reg(j);
        end
        for (int i = 3; i < 8; i++) chk_reg(i);
        $display("refusals and readback done");
        close_out();
    end
endmodule // buck_regulator_config_regs_tb
